/* gain_cal_pkg.sv */
// Purpose: shared constants and types for the converter gain calibration registers
// Assumes: 32-bit memory-mapped register port, 16-bit coefficients in the low half
// Notes: factory trim arrives on input ports; the reset values here only stand until the trim loads
package gain_cal_pkg;
   localparam int COEFF_W = 16;
   localparam logic [31:0] CURRENT_GAIN_ADDR = 32'hFFFF053C;
   localparam logic [31:0] VOLTAGE_GAIN_ADDR = 32'hFFFF0540;
   localparam logic [15:0] COEFF_RESET = 16'h0000;
   localparam int CLOCK_HZ = 20000000;
   localparam int IDLE_TIME_NS = 23000;
   // least time rounds up to whole cycles
   localparam int IDLE_CYCLES = (IDLE_TIME_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
   localparam int IDLE_CNT_W = 10;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [31:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic start;
      logic [15:0] value;
   } cal_load_t;

   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_WAIT = 3'b010,
      ST_OPEN = 3'b100
   } wr_gate_t;
endpackage

/* adc_gain_calibration_regs.sv */
// Purpose: current and voltage channel gain coefficient registers with write gating
// Assumes: converter mode state (enabled, idle) and calibration results come from same-clock logic
// Notes: trim values are sampled during the power-on load pulse, not under reset
//
// Notes on behaviour
// - keep a 16-bit current-channel gain coefficient that scales its results.
// - keep a separate 16-bit voltage-channel gain coefficient for its results.
// - at power-on load each coefficient from its factory trim value.
// - a current-channel gain calibration overwrites the current coefficient.
// - a voltage-channel gain calibration overwrites the voltage coefficient.
// - software writes accepted only after enabled and idle for 23 us.
// - both coefficients are readable and writable through the register port.
`timescale 1ns/1ps
module adc_gain_calibration_regs
   import gain_cal_pkg::*;
#(
   parameter int IDLE_COUNT = IDLE_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic trim_load,
   input wire logic [COEFF_W-1:0] current_trim,
   input wire logic [COEFF_W-1:0] voltage_trim,
   input wire logic converter_enabled,
   input wire logic converter_idle,
   input wire cal_load_t current_cal,
   input wire cal_load_t voltage_cal,
   input wire reg_req_t req,
   output logic [31:0] rdata,
   output logic rvalid,
   output logic [COEFF_W-1:0] current_gain,
   output logic [COEFF_W-1:0] voltage_gain,
   output logic write_open
);
   logic [COEFF_W-1:0] cur_q, cur_d, vol_q, vol_d;
   logic [IDLE_CNT_W-1:0] cnt_q, cnt_d;
   wr_gate_t st_q, st_d;
   logic [31:0] rdata_q, rdata_d;
   logic rvalid_q, open_q;

   wire idle_now = converter_enabled & converter_idle;
   wire hit_cur = req.addr == CURRENT_GAIN_ADDR;
   wire hit_vol = req.addr == VOLTAGE_GAIN_ADDR;
   wire gate_open = st_q == ST_OPEN;
   wire wr_cur = req.wr & hit_cur & gate_open;
   wire wr_vol = req.wr & hit_vol & gate_open;
   wire [IDLE_CNT_W-1:0] idle_last = IDLE_CNT_W'(IDLE_COUNT - 1);

   // idle timer: any drop of enable or idle restarts the 23 us wait
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      case (st_q)
         ST_OFF: begin
            cnt_d = '0;
            if (idle_now) st_d = ST_WAIT;
         end
         ST_WAIT: begin
            if (!idle_now) begin
               st_d = ST_OFF;
            end else if (cnt_q == idle_last) begin
               st_d = ST_OPEN;
            end else begin
               cnt_d = cnt_q + IDLE_CNT_W'(1);
            end
         end
         ST_OPEN: begin
            if (!idle_now) st_d = ST_OFF;
         end
         default: st_d = ST_OFF;
      endcase
   end

   // calibration results outrank a software write in the same cycle
   always_comb begin
      cur_d = cur_q;
      vol_d = vol_q;
      if (trim_load) begin
         cur_d = current_trim;
         vol_d = voltage_trim;
      end else begin
         if (current_cal.start) cur_d = current_cal.value;
         else if (wr_cur) cur_d = req.wdata[COEFF_W-1:0];
         if (voltage_cal.start) vol_d = voltage_cal.value;
         else if (wr_vol) vol_d = req.wdata[COEFF_W-1:0];
      end
   end

   // unmapped addresses read as zero
   assign rdata_d = hit_cur ? {16'h0000, cur_q} : hit_vol ? {16'h0000, vol_q} : 32'h00000000;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cur_q <= COEFF_RESET;
         vol_q <= COEFF_RESET;
         st_q <= ST_OFF;
         cnt_q <= '0;
         rdata_q <= '0;
         rvalid_q <= 1'b0;
         open_q <= 1'b0;
      end else begin
         cur_q <= cur_d;
         vol_q <= vol_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         rdata_q <= req.rd ? rdata_d : rdata_q;
         rvalid_q <= req.rd;
         open_q <= st_d == ST_OPEN;
      end
   end

   assign rdata = rdata_q;
   assign rvalid = rvalid_q;
   assign current_gain = cur_q;
   assign voltage_gain = vol_q;
   assign write_open = open_q;

   // assertion helper: edges in a row with the converter enabled and idle, saturating
   logic [IDLE_CNT_W:0] idle_run_q;
   wire idle_run_full = idle_run_q == '1;

   always_ff @(posedge clock) begin
      if (!rst_n || !idle_now) begin
         idle_run_q <= '0;
      end else if (!idle_run_full) begin
         idle_run_q <= idle_run_q + 1'b1;
      end
   end

   property p_trim_cur;
      @(posedge clock) disable iff (!rst_n) trim_load |=> cur_q == $past(current_trim);
   endproperty
   a_trim_cur: assert property (p_trim_cur) else $error("current trim not loaded");

   property p_trim_vol;
      @(posedge clock) disable iff (!rst_n) trim_load |=> vol_q == $past(voltage_trim);
   endproperty
   a_trim_vol: assert property (p_trim_vol) else $error("voltage trim not loaded");

   property p_cal_cur;
      @(posedge clock) disable iff (!rst_n) (!trim_load && current_cal.start) |=> cur_q == $past(current_cal.value);
   endproperty
   a_cal_cur: assert property (p_cal_cur) else $error("current calibration not taken");

   property p_cal_vol;
      @(posedge clock) disable iff (!rst_n) (!trim_load && voltage_cal.start) |=> vol_q == $past(voltage_cal.value);
   endproperty
   a_cal_vol: assert property (p_cal_vol) else $error("voltage calibration not taken");

   property p_early_cur;
      @(posedge clock) disable iff (!rst_n)
         (req.wr && hit_cur && !gate_open && !trim_load && !current_cal.start) |=> $stable(cur_q);
   endproperty
   a_early_cur: assert property (p_early_cur) else $error("early current write changed coefficient");

   property p_early_vol;
      @(posedge clock) disable iff (!rst_n)
         (req.wr && hit_vol && !gate_open && !trim_load && !voltage_cal.start) |=> $stable(vol_q);
   endproperty
   a_early_vol: assert property (p_early_vol) else $error("early voltage write changed coefficient");

   property p_write_cur;
      @(posedge clock) disable iff (!rst_n)
         (req.wr && hit_cur && gate_open && !trim_load && !current_cal.start) |=> cur_q == $past(req.wdata[COEFF_W-1:0]);
   endproperty
   a_write_cur: assert property (p_write_cur) else $error("current write lost");

   property p_write_vol;
      @(posedge clock) disable iff (!rst_n)
         (req.wr && hit_vol && gate_open && !trim_load && !voltage_cal.start) |=> vol_q == $past(req.wdata[COEFF_W-1:0]);
   endproperty
   a_write_vol: assert property (p_write_vol) else $error("voltage write lost");

   property p_open_needs_idle;
      @(posedge clock) disable iff (!rst_n) $rose(gate_open) |-> $past(idle_now) && $past(st_q) == ST_WAIT;
   endproperty
   a_open_needs_idle: assert property (p_open_needs_idle) else $error("gate opened without idle");

   // the gate is open exactly when more than IDLE_COUNT idle edges have passed in a row
   property p_gate_after_idle;
      @(posedge clock) disable iff (!rst_n) gate_open |-> int'(idle_run_q) > IDLE_COUNT;
   endproperty
   a_gate_after_idle: assert property (p_gate_after_idle) else $error("gate open before the idle time");

   property p_gate_opens;
      @(posedge clock) disable iff (!rst_n) int'(idle_run_q) > IDLE_COUNT |-> gate_open;
   endproperty
   a_gate_opens: assert property (p_gate_opens) else $error("gate still shut after the idle time");

   property p_gate_closes;
      @(posedge clock) disable iff (!rst_n) !idle_now |=> !gate_open && !write_open;
   endproperty
   a_gate_closes: assert property (p_gate_closes) else $error("gate stayed open without idle");

   property p_read_cur;
      @(posedge clock) disable iff (!rst_n) (req.rd && hit_cur) |=> rvalid && rdata == {16'h0000, $past(cur_q)};
   endproperty
   a_read_cur: assert property (p_read_cur) else $error("current read wrong");

   property p_read_vol;
      @(posedge clock) disable iff (!rst_n) (req.rd && hit_vol) |=> rvalid && rdata == {16'h0000, $past(vol_q)};
   endproperty
   a_read_vol: assert property (p_read_vol) else $error("voltage read wrong");

   property p_read_other;
      @(posedge clock) disable iff (!rst_n) (req.rd && !hit_cur && !hit_vol) |=> rvalid && rdata == 32'h00000000;
   endproperty
   a_read_other: assert property (p_read_other) else $error("unmapped read not zero");

   property p_rvalid_pulse;
      @(posedge clock) disable iff (!rst_n) !req.rd |=> !rvalid;
   endproperty
   a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without a read");

   property p_rdata_hold;
      @(posedge clock) disable iff (!rst_n) !req.rd |=> $stable(rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

   property p_hold_cur;
      @(posedge clock) disable iff (!rst_n) (!trim_load && !current_cal.start && !wr_cur) |=> $stable(cur_q);
   endproperty
   a_hold_cur: assert property (p_hold_cur) else $error("current coefficient moved on its own");

   property p_hold_vol;
      @(posedge clock) disable iff (!rst_n) (!trim_load && !voltage_cal.start && !wr_vol) |=> $stable(vol_q);
   endproperty
   a_hold_vol: assert property (p_hold_vol) else $error("voltage coefficient moved on its own");

   c_open: cover property (@(posedge clock) disable iff (!rst_n) $rose(gate_open));
   c_cal: cover property (@(posedge clock) disable iff (!rst_n) current_cal.start && voltage_cal.start);
   c_wr: cover property (@(posedge clock) disable iff (!rst_n) wr_cur ##1 req.rd && hit_cur);
   c_close: cover property (@(posedge clock) disable iff (!rst_n) gate_open && !idle_now);
   c_trim_win: cover property (@(posedge clock) disable iff (!rst_n) trim_load && current_cal.start && req.wr);
endmodule

/* adc_gain_calibration_regs_tb.sv */
// Purpose: self-checking bench for the gain coefficient registers
// Assumes: shortened idle count; inputs change on the falling edge
// Notes: the model keeps both coefficients as ints and whether the write gate should be open
`timescale 1ns/1ps
module adc_gain_calibration_regs_tb;
   import gain_cal_pkg::*;
   localparam int IDLE_N = 4;
   logic clock, rst_n, trim_load, en, idle, rvalid, write_open;
   logic [15:0] ctrim, vtrim, cur_g, vol_g;
   logic [31:0] rdata;
   cal_load_t ccal, vcal;
   reg_req_t req;
   int fails, compares, cur_m, vol_m;
   bit open_m;
   int run_m;
   logic [31:0] rdata_m;
   adc_gain_calibration_regs #(.IDLE_COUNT(IDLE_N)) uut (.clock(clock), .rst_n(rst_n), .trim_load(trim_load),
      .current_trim(ctrim), .voltage_trim(vtrim), .converter_enabled(en), .converter_idle(idle),
      .current_cal(ccal), .voltage_cal(vcal), .req(req), .rdata(rdata), .rvalid(rvalid),
      .current_gain(cur_g), .voltage_gain(vol_g), .write_open(write_open));
   initial begin
      clock = 0;
      forever #25 clock = ~clock;
   end
   // reference model: one step per rising edge, from the values the bench drove
   always @(posedge clock) begin
      if (!rst_n) begin
         cur_m = 0;
         vol_m = 0;
         rdata_m = '0;
         run_m = 0;
      end else begin
         // a read returns the coefficient as it stood before this edge
         if (req.rd && req.addr == CURRENT_GAIN_ADDR) rdata_m = 32'(cur_m);
         else if (req.rd && req.addr == VOLTAGE_GAIN_ADDR) rdata_m = 32'(vol_m);
         else if (req.rd) rdata_m = '0;
         if (trim_load) begin
            cur_m = ctrim;
            vol_m = vtrim;
         end else begin
            if (ccal.start) cur_m = ccal.value;
            else if (req.wr && open_m && req.addr == CURRENT_GAIN_ADDR) cur_m = req.wdata[15:0];
            if (vcal.start) vol_m = vcal.value;
            else if (req.wr && open_m && req.addr == VOLTAGE_GAIN_ADDR) vol_m = req.wdata[15:0];
         end
         // any edge without enable and idle restarts the wait
         run_m = (en && idle) ? run_m + 1 : 0;
      end
      open_m = run_m > IDLE_N;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(negedge clock);
      req.wr = 1;
      req.addr = a;
      req.wdata = d;
      @(negedge clock);
      req.wr = 0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      @(negedge clock);
      req.rd = 1;
      req.addr = a;
      @(negedge clock);
      req.rd = 0;
      chk("rvalid", 32'(rvalid), 32'h1);
      chk("rdata", rdata, e);
   endtask
   task automatic check_all();
      chk("current_gain", 32'(cur_g), 32'(cur_m[15:0]));
      chk("voltage_gain", 32'(vol_g), 32'(vol_m[15:0]));
      rd(CURRENT_GAIN_ADDR, 32'(cur_m[15:0]));
      rd(VOLTAGE_GAIN_ADDR, 32'(vol_m[15:0]));
      chk("write_open", 32'(write_open), 32'(open_m));
      // rvalid stands one cycle, rdata until the next read
      @(negedge clock);
      chk("rvalid", 32'(rvalid), 32'h0);
      chk("rdata", rdata, rdata_m);
   endtask
   task automatic give_verdict();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clock);
      fails++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'hC7D4BAF4));
      {rst_n, trim_load, en, idle, ctrim, vtrim} = '0;
      ccal = '0;
      vcal = '0;
      req = '0;
      repeat (20) @(negedge clock);
      rst_n = 1;
      ctrim = 16'($urandom);
      vtrim = 16'($urandom);
      trim_load = 1;
      @(negedge clock);
      trim_load = 0;
      check_all();
      wr(CURRENT_GAIN_ADDR, $urandom);
      wr(VOLTAGE_GAIN_ADDR, $urandom);
      check_all();
      en = 1;
      idle = 1;
      // a write on every edge from the second of the idle time on: only those after the gate opens may land
      for (int i = 0; i < IDLE_N + 3; i++) begin
         @(negedge clock);
         chk("write_open", 32'(write_open), 32'(open_m));
         chk("current_gain", 32'(cur_g), 32'(cur_m[15:0]));
         chk("voltage_gain", 32'(vol_g), 32'(vol_m[15:0]));
         req = '{wr: 1'b1, rd: 1'b0, addr: i[0] ? VOLTAGE_GAIN_ADDR : CURRENT_GAIN_ADDR, wdata: $urandom};
      end
      @(negedge clock);
      req.wr = 0;
      chk("write_open", 32'(write_open), 32'h1);
      check_all();
      wr(CURRENT_GAIN_ADDR, $urandom);
      wr(VOLTAGE_GAIN_ADDR, $urandom);
      wr(VOLTAGE_GAIN_ADDR + 32'h8, $urandom);
      check_all();
      rd(VOLTAGE_GAIN_ADDR + 32'h8, 32'h0);
      // calibration lands in the same cycle as a write and must win
      // the third pass calibrates both channels at once
      for (int ch = 0; ch < 3; ch++) begin
         @(negedge clock);
         if (ch != 1) ccal = '{start: 1'b1, value: 16'($urandom)};
         if (ch != 0) vcal = '{start: 1'b1, value: 16'($urandom)};
         req = '{wr: 1'b1, rd: 1'b0, addr: ch == 1 ? VOLTAGE_GAIN_ADDR : CURRENT_GAIN_ADDR, wdata: $urandom};
         @(negedge clock);
         ccal.start = 0;
         vcal.start = 0;
         req.wr = 0;
         check_all();
      end
      // write then read of the same register on back-to-back edges
      @(negedge clock);
      req = '{wr: 1'b1, rd: 1'b0, addr: CURRENT_GAIN_ADDR, wdata: $urandom};
      @(negedge clock);
      req = '{wr: 1'b0, rd: 1'b1, addr: CURRENT_GAIN_ADDR, wdata: 32'h00000000};
      @(negedge clock);
      req.rd = 0;
      chk("rvalid", 32'(rvalid), 32'h1);
      chk("rdata", rdata, 32'(cur_m[15:0]));
      idle = 0;
      repeat (2) @(negedge clock);
      chk("write_open", 32'(write_open), 32'h0);
      wr(CURRENT_GAIN_ADDR, $urandom);
      check_all();
      // mid-run reset, then trim, calibration and write together on the first edge after release
      rst_n = 0;
      repeat (2) @(negedge clock);
      chk("current_gain", 32'(cur_g), 32'(COEFF_RESET));
      chk("voltage_gain", 32'(vol_g), 32'(COEFF_RESET));
      chk("rdata", rdata, 32'h00000000);
      chk("rvalid", 32'(rvalid), 32'h0);
      chk("write_open", 32'(write_open), 32'h0);
      rst_n = 1;
      ctrim = 16'($urandom);
      vtrim = 16'($urandom);
      trim_load = 1;
      ccal = '{start: 1'b1, value: 16'($urandom)};
      req = '{wr: 1'b1, rd: 1'b0, addr: CURRENT_GAIN_ADDR, wdata: $urandom};
      @(negedge clock);
      trim_load = 0;
      ccal.start = 0;
      req.wr = 0;
      check_all();
      give_verdict();
   end
endmodule
